// ---- core/emd_ext_mem_port.v ----
/*
 External memory port pin logic: data bus, read and write strobes,
 address and select qualification, port F sharing and pull-ups.
 Assumes one 10 MHz clock; requests from the core arrive through a FIFO;
 pin inputs are asynchronous.
*/
`timescale 1ns/1ps
`include "emd_consts.vh"
module emd_ext_mem_port #(
   parameter SETUP_CYC  = `EMD_SETUP_CYC,
   parameter RD_LOW_CYC = `EMD_RD_LOW_CYC,
   parameter WR_LOW_CYC = `EMD_WR_LOW_CYC,
   parameter HOLD_CYC   = `EMD_HOLD_CYC,
   parameter FIFO_DEPTH = `EMD_FIFO_DEPTH
) (
   // Clock and reset
   input  wire                      i_clock,
   input  wire                      i_rstn,
   // Access requests
   input  wire                      i_req_valid,
   input  wire                      i_req_write,
   input  wire                      i_req_program,
   input  wire [`EMD_ADDR_W-1:0]    i_req_addr,
   input  wire [`EMD_DATA_W-1:0]    i_req_wdata,
   output wire                      o_req_ready,
   // Read answers
   output reg                       o_rd_valid,
   output reg  [`EMD_DATA_W-1:0]    o_rd_data,
   output reg                       o_busy,
   // Configuration bits
   input  wire                      i_bus_keep_driven,
   input  wire [`EMD_PORTF_W-1:0]   i_port_f_gpio_sel,
   input  wire [`EMD_PORTF_W-1:0]   i_port_f_dir_out,
   input  wire [`EMD_PORTF_W-1:0]   i_port_f_out,
   input  wire [`EMD_PORTF_W-1:0]   i_port_f_pullup_enable,
   input  wire                      i_ctrl_pullup_disable,
   output wire [`EMD_PORTF_W-1:0]   o_port_f_in,
   // Data bus pins
   input  wire [`EMD_DATA_W-1:0]    i_ext_data_bus,
   output reg  [`EMD_DATA_W-1:0]    o_ext_data_bus,
   output reg  [`EMD_DATA_W-1:0]    o_ext_data_oe_n,
   output reg  [`EMD_PORTF_W-1:0]   o_port_f_pullup_on,
   // Strobe, address and select pins
   output reg                       o_rd_n,
   output reg                       o_wr_n,
   output reg  [`EMD_ADDR_W-1:0]    o_ext_address_bus,
   output reg                       o_program_mem_select_n,
   output reg                       o_data_mem_select_n,
   output reg                       o_ctrl_oe_n,
   output reg                       o_strobe_pullup_on
);

   // ----------------------------------------
   // States and declarations
   // ----------------------------------------
   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_SETUP  = 2'h1;
   localparam [1:0] ST_STROBE = 2'h2;
   localparam [1:0] ST_HOLD   = 2'h3;

   reg  [1:0]                state_ff;
   reg  [1:0]                nxt_state;
   reg  [`EMD_CNT_W-1:0]     cnt_ff;
   reg  [`EMD_CNT_W-1:0]     nxt_cnt;
   reg                       we_ff;
   reg                       nxt_we;
   reg                       prog_ff;
   reg                       nxt_prog;
   reg  [`EMD_DATA_W-1:0]    wdata_ff;
   reg  [`EMD_DATA_W-1:0]    nxt_wdata;
   reg  [`EMD_ADDR_W-1:0]    nxt_addr;
   reg                       nxt_rd_n;
   reg                       nxt_wr_n;
   reg                       nxt_pms_n;
   reg                       nxt_dms_n;
   reg                       nxt_ctrl_oe_n;
   reg  [`EMD_DATA_W-1:0]    nxt_data_out;
   reg  [`EMD_DATA_W-1:0]    nxt_data_oe_n;
   reg                       bus_oe_n;
   reg                       active;
   reg                       capture;
   integer                   i;
   integer                   j;

   reg  [`EMD_DATA_W-1:0]    sync1_ff;
   reg  [`EMD_DATA_W-1:0]    sync2_ff;
   reg  [`EMD_DATA_W-1:0]    sync3_ff;
   reg  [`EMD_DATA_W-1:0]    pin_ff;
   reg  [`EMD_DATA_W-1:0]    nxt_pin;

   wire                      fifo_valid;
   wire [`EMD_REQ_W-1:0]     fifo_data;
   wire                      fifo_take;

   // ----------------------------------------
   // Count helper
   // ----------------------------------------
   function [`EMD_CNT_W-1:0] cyc_load;
      input integer cycles;
      begin
         cyc_load = (cycles > 1) ? cycles[`EMD_CNT_W-1:0] - 1'b1 : {`EMD_CNT_W{1'b0}};
      end
   endfunction

   // ----------------------------------------
   // Request FIFO
   // ----------------------------------------
   // Only taken while idle, so a request never alters a live cycle
   assign fifo_take = (state_ff == ST_IDLE);

   emd_fifo #(
      .WIDTH (`EMD_REQ_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .i_clock  (i_clock),
      .i_rstn   (i_rstn),
      .i_wvalid (i_req_valid),
      .i_wdata  ({i_req_write, i_req_program, i_req_addr, i_req_wdata}),
      .o_wready (o_req_ready),
      .o_rvalid (fifo_valid),
      .o_rdata  (fifo_data),
      .i_rready (fifo_take)
   );

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   // Accepted value moves only when stages two and three agree
   always @* begin
      nxt_pin = pin_ff;
      for (j = 0; j < `EMD_DATA_W; j = j + 1) begin
         if (sync2_ff[j] == sync3_ff[j]) begin
            nxt_pin[j] = sync3_ff[j];
         end
      end
   end

   always @(posedge i_clock) begin
      if (!i_rstn) begin
         sync1_ff <= {`EMD_DATA_W{1'b0}};
         sync2_ff <= {`EMD_DATA_W{1'b0}};
         sync3_ff <= {`EMD_DATA_W{1'b0}};
         pin_ff   <= {`EMD_DATA_W{1'b0}};
      end else begin
         sync1_ff <= i_ext_data_bus;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         pin_ff   <= nxt_pin;
      end
   end

   assign o_port_f_in = pin_ff[`EMD_DATA_W-1:`EMD_PORTF_LSB];

   // ----------------------------------------
   // Access sequencer
   // ----------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_we    = we_ff;
      nxt_prog  = prog_ff;
      nxt_wdata = wdata_ff;
      nxt_addr  = o_ext_address_bus;
      capture   = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (fifo_valid) begin
               nxt_state = ST_SETUP;
               nxt_cnt   = cyc_load(SETUP_CYC);
               nxt_we    = fifo_data[`EMD_REQ_WE_BIT];
               nxt_prog  = fifo_data[`EMD_REQ_PROG_BIT];
               nxt_addr  = fifo_data[`EMD_REQ_ADDR_MSB:`EMD_REQ_ADDR_LSB];
               nxt_wdata = fifo_data[`EMD_REQ_DATA_MSB:0];
            end
         end
         ST_SETUP: begin
            if (cnt_ff == {`EMD_CNT_W{1'b0}}) begin
               nxt_state = ST_STROBE;
               nxt_cnt   = we_ff ? cyc_load(WR_LOW_CYC) : cyc_load(RD_LOW_CYC);
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         ST_STROBE: begin
            if (cnt_ff == {`EMD_CNT_W{1'b0}}) begin
               nxt_state = ST_HOLD;
               nxt_cnt   = cyc_load(HOLD_CYC);
               // Same edge that raises the read strobe
               capture   = !we_ff;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         ST_HOLD: begin
            if (cnt_ff == {`EMD_CNT_W{1'b0}}) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Pin next values
   // ----------------------------------------
   always @* begin
      active = (nxt_state != ST_IDLE);
      // One sequencer, so only one strobe can ever be low
      nxt_rd_n  = !((nxt_state == ST_STROBE) && !nxt_we);
      nxt_wr_n  = !((nxt_state == ST_STROBE) && nxt_we);
      // Selects follow the access type for the whole cycle
      nxt_pms_n = !(active && nxt_prog);
      nxt_dms_n = !(active && !nxt_prog);
      nxt_ctrl_oe_n = active ? 1'b0 : !i_bus_keep_driven;
      // Write data stays on the bus through the hold after the rise
      if (active) begin
         bus_oe_n = !nxt_we;
      end else begin
         bus_oe_n = !i_bus_keep_driven;
      end
      nxt_data_out  = nxt_wdata;
      nxt_data_oe_n = {`EMD_DATA_W{bus_oe_n}};
      // Port F bits leave the bus only when selected as general purpose
      for (i = 0; i < `EMD_PORTF_W; i = i + 1) begin
         if (i_port_f_gpio_sel[i]) begin
            nxt_data_out[i+`EMD_PORTF_LSB]  = i_port_f_out[i];
            nxt_data_oe_n[i+`EMD_PORTF_LSB] = !i_port_f_dir_out[i];
         end
      end
   end

   // ----------------------------------------
   // Registers and pins
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (!i_rstn) begin
         state_ff               <= ST_IDLE;
         cnt_ff                 <= {`EMD_CNT_W{1'b0}};
         we_ff                  <= 1'b0;
         prog_ff                <= 1'b0;
         wdata_ff               <= {`EMD_DATA_W{1'b0}};
         o_ext_data_bus         <= {`EMD_DATA_W{1'b0}};
         // Outputs disabled in reset; pins default to bus function
         o_ext_data_oe_n        <= {`EMD_DATA_W{1'b1}};
         o_rd_n                 <= 1'b1;
         o_wr_n                 <= 1'b1;
         o_ext_address_bus      <= {`EMD_ADDR_W{1'b0}};
         o_program_mem_select_n <= 1'b1;
         o_data_mem_select_n    <= 1'b1;
         o_ctrl_oe_n            <= 1'b1;
      end else begin
         state_ff               <= nxt_state;
         cnt_ff                 <= nxt_cnt;
         we_ff                  <= nxt_we;
         prog_ff                <= nxt_prog;
         wdata_ff               <= nxt_wdata;
         o_ext_data_bus         <= nxt_data_out;
         o_ext_data_oe_n        <= nxt_data_oe_n;
         o_rd_n                 <= nxt_rd_n;
         o_wr_n                 <= nxt_wr_n;
         // Address loads only on leaving idle, held while strobes low
         o_ext_address_bus      <= nxt_addr;
         o_program_mem_select_n <= nxt_pms_n;
         o_data_mem_select_n    <= nxt_dms_n;
         o_ctrl_oe_n            <= nxt_ctrl_oe_n;
      end
   end

   // ----------------------------------------
   // Read answer
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (!i_rstn) begin
         o_rd_valid <= 1'b0;
         o_rd_data  <= {`EMD_DATA_W{1'b0}};
         o_busy     <= 1'b0;
      end else begin
         // Read data is the bus sampled two and three edges before the edge that raises the read strobe, through the filter
         o_rd_valid <= capture;
         // Filter output of this edge; the registered copy lags a cycle
         if (capture) begin
            o_rd_data <= nxt_pin;
         end
         o_busy     <= (nxt_state != ST_IDLE);
      end
   end

   // ----------------------------------------
   // Pull-up controls
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (!i_rstn) begin
         o_port_f_pullup_on <= `EMD_RST_PULLUP;
         o_strobe_pullup_on <= 1'b1;
      end else begin
         o_port_f_pullup_on <= i_port_f_pullup_enable;
         o_strobe_pullup_on <= !i_ctrl_pullup_disable;
      end
   end

endmodule

// ---- core/emd_consts.vh ----
/*
 Constants for the external memory data and strobe pin logic.
 Assumes a 10 MHz system clock; included by bare name.
*/
`ifndef EMD_CONSTS_VH
`define EMD_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define EMD_DATA_W        16
`define EMD_ADDR_W        17
`define EMD_PORTF_W       9
`define EMD_PORTF_LSB     7
`define EMD_REQ_W         35
`define EMD_FIFO_DEPTH    8

// ----------------------------------------
// Request word layout
// ----------------------------------------
`define EMD_REQ_WE_BIT    34
`define EMD_REQ_PROG_BIT  33
`define EMD_REQ_ADDR_MSB  32
`define EMD_REQ_ADDR_LSB  16
`define EMD_REQ_DATA_MSB  15

// ----------------------------------------
// Timing
// ----------------------------------------
`define EMD_CLK_NS        100
`define EMD_SETUP_NS      100
`define EMD_RD_LOW_NS     400
`define EMD_WR_LOW_NS     300
`define EMD_HOLD_NS       100
`define EMD_SETUP_CYC     ((`EMD_SETUP_NS + `EMD_CLK_NS - 1) / `EMD_CLK_NS)
`define EMD_RD_LOW_CYC    ((`EMD_RD_LOW_NS + `EMD_CLK_NS - 1) / `EMD_CLK_NS)
`define EMD_WR_LOW_CYC    ((`EMD_WR_LOW_NS + `EMD_CLK_NS - 1) / `EMD_CLK_NS)
`define EMD_HOLD_CYC      ((`EMD_HOLD_NS + `EMD_CLK_NS - 1) / `EMD_CLK_NS)
`define EMD_CNT_W         8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EMD_RST_PULLUP    9'h1ff

`endif

// ---- core/emd_fifo.v ----
/*
 Request FIFO with registered read data and registered write ready.
 Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module emd_fifo #(
   parameter WIDTH = 35,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             i_clock,
   input  wire             i_rstn,
   // Fill side
   input  wire             i_wvalid,
   input  wire [WIDTH-1:0] i_wdata,
   output reg              o_wready,
   // Drain side
   output reg              o_rvalid,
   output reg  [WIDTH-1:0] o_rdata,
   input  wire             i_rready
);

   // ----------------------------------------
   // Storage and pointers
   // ----------------------------------------
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wptr_ff;
   reg [AW-1:0]    rptr_ff;
   reg [AW:0]      count_ff;
   reg [AW:0]      nxt_count;
   wire            push;
   wire            pop;

   assign push = i_wvalid && o_wready;
   // Output stage refills when empty or being taken
   assign pop  = (count_ff != {(AW+1){1'b0}}) && (!o_rvalid || i_rready);

   always @* begin
      nxt_count = count_ff;
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   always @(posedge i_clock) begin
      if (push) begin
         mem_ff[wptr_ff] <= i_wdata;
      end
   end

   always @(posedge i_clock) begin
      if (!i_rstn) begin
         wptr_ff  <= {AW{1'b0}};
         rptr_ff  <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
         o_wready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata  <= {WIDTH{1'b0}};
      end else begin
         count_ff <= nxt_count;
         // Registered ready is one cycle pessimistic, never overfills
         o_wready <= (nxt_count < DEPTH[AW:0]);
         if (push) begin
            wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
         end
         if (pop) begin
            o_rdata  <= mem_ff[rptr_ff];
            o_rvalid <= 1'b1;
            rptr_ff  <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ---- tb/emd_port_sva.sv ----
/* Concurrent checks on the external memory pin logic top ports.
   Assumes the default strobe lengths unless the bind overrides them. */
`timescale 1ns/1ps
module emd_port_sva #(
   parameter RD_LOW_CYC = 4,
   parameter WR_LOW_CYC = 3
) (
   // Clock, reset, configuration
   input wire logic        i_clock,
   input wire logic        i_rstn,
   input wire logic        i_bus_keep_driven,
   input wire logic [8:0]  i_port_f_gpio_sel,
   input wire logic [8:0]  i_port_f_pullup_enable,
   input wire logic        i_ctrl_pullup_disable,
   input wire logic [15:0] i_ext_data_bus,
   // Outputs watched
   input wire logic        o_busy,
   input wire logic        o_rd_valid,
   input wire logic [15:0] o_rd_data,
   input wire logic [15:0] o_ext_data_bus,
   input wire logic [15:0] o_ext_data_oe_n,
   input wire logic [8:0]  o_port_f_pullup_on,
   input wire logic        o_rd_n,
   input wire logic        o_wr_n,
   input wire logic [16:0] o_ext_address_bus,
   input wire logic        o_program_mem_select_n,
   input wire logic        o_data_mem_select_n,
   input wire logic        o_ctrl_oe_n,
   input wire logic        o_strobe_pullup_on
);
   // ----------------------------------------
   // Strobe length counter
   // ----------------------------------------
   logic [7:0] lo_cnt_ff;
   wire        strobe = !o_rd_n || !o_wr_n;
   always @(posedge i_clock) begin
      if (!i_rstn) lo_cnt_ff <= 8'h00;
      else lo_cnt_ff <= strobe ? lo_cnt_ff + 8'h01 : 8'h00;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   // Read answer is a single-cycle pulse with the bus word
   sequence s_rd_done;
      o_rd_valid && o_rd_data == $past(i_ext_data_bus) ##1 !o_rd_valid;
   endsequence
   property p_rd_dir;
      !o_rd_n |-> (o_ext_data_oe_n | {i_port_f_gpio_sel, 7'h00}) == 16'hffff;
   endproperty
   property p_wr_dir;
      !o_wr_n |-> (o_ext_data_oe_n & ~{i_port_f_gpio_sel, 7'h00}) == 16'h0000;
   endproperty
   property p_excl;
      o_rd_n || o_wr_n;
   endproperty
   property p_stable;
      strobe && $past(strobe) |-> $stable(o_ext_address_bus)
         && $stable(o_program_mem_select_n) && $stable(o_data_mem_select_n);
   endproperty
   property p_sel;
      strobe |-> !o_ctrl_oe_n && (o_program_mem_select_n != o_data_mem_select_n);
   endproperty
   property p_rd_len;
      $rose(o_rd_n) |-> lo_cnt_ff == RD_LOW_CYC;
   endproperty
   property p_wr_len;
      $rose(o_wr_n) |-> lo_cnt_ff == WR_LOW_CYC;
   endproperty
   property p_rd_cap;
      $rose(o_rd_n) |-> s_rd_done;
   endproperty
   property p_wr_hold;
      $rose(o_wr_n) |-> $stable(o_ext_data_bus) && o_ext_data_oe_n[6:0] == 7'h00;
   endproperty
   // Two quiet cycles, so the tail of an access is never judged as idle
   property p_idle;
      !o_busy && $past(!o_busy) && $past(i_rstn) && $stable(i_bus_keep_driven)
         |-> o_ctrl_oe_n == !i_bus_keep_driven
         && o_ext_data_oe_n[6:0] == {7{!i_bus_keep_driven}};
   endproperty
   property p_spu;
      $past(i_rstn) |-> o_strobe_pullup_on == !$past(i_ctrl_pullup_disable);
   endproperty
   property p_fpu;
      $past(i_rstn) |-> o_port_f_pullup_on == $past(i_port_f_pullup_enable);
   endproperty
   a_rd_dir: assert property (p_rd_dir) else $error("pins driven in read");
   a_wr_dir: assert property (p_wr_dir) else $error("pins idle in write");
   a_excl: assert property (p_excl) else $error("both strobes low");
   a_stable: assert property (p_stable) else $error("address moved");
   a_sel: assert property (p_sel) else $error("bad select");
   a_rd_len: assert property (p_rd_len) else $error("read strobe length");
   a_wr_len: assert property (p_wr_len) else $error("write strobe length");
   a_rd_cap: assert property (p_rd_cap) else $error("read capture");
   a_wr_hold: assert property (p_wr_hold) else $error("write data hold");
   a_idle: assert property (p_idle) else $error("idle drive");
   a_spu: assert property (p_spu) else $error("strobe pull-up");
   a_fpu: assert property (p_fpu) else $error("port pull-up");
endmodule
bind emd_ext_mem_port emd_port_sva #(.RD_LOW_CYC(RD_LOW_CYC), .WR_LOW_CYC(WR_LOW_CYC)) u_sva (
   .i_clock(i_clock), .i_rstn(i_rstn), .i_bus_keep_driven(i_bus_keep_driven),
   .i_port_f_gpio_sel(i_port_f_gpio_sel), .i_port_f_pullup_enable(i_port_f_pullup_enable),
   .i_ctrl_pullup_disable(i_ctrl_pullup_disable), .i_ext_data_bus(i_ext_data_bus),
   .o_busy(o_busy), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
   .o_ext_data_bus(o_ext_data_bus), .o_ext_data_oe_n(o_ext_data_oe_n),
   .o_port_f_pullup_on(o_port_f_pullup_on), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
   .o_ext_address_bus(o_ext_address_bus), .o_program_mem_select_n(o_program_mem_select_n),
   .o_data_mem_select_n(o_data_mem_select_n), .o_ctrl_oe_n(o_ctrl_oe_n),
   .o_strobe_pullup_on(o_strobe_pullup_on));

// ---- tb/emd_sram_model.sv ----
/* Behavioural asynchronous static memory on the external bus.
   Assumes the bench resolves the data wire and supplies pull-ups. */
`timescale 1ns/1ps
module emd_sram_model (
   // Control
   input wire logic        i_slow,
   input wire logic        i_rd_n,
   input wire logic        i_wr_n,
   input wire logic        i_prog_sel_n,
   input wire logic        i_data_sel_n,
   input wire logic [16:0] i_addr,
   input wire logic [15:0] i_data,
   // Drive back onto the bus
   output logic            o_drive,
   output logic [15:0]     o_data
);
   logic [15:0] mem [int];
   wire         sel = !i_prog_sel_n || !i_data_sel_n;
   wire  [17:0] key = {!i_prog_sel_n, i_addr};
   initial begin
      o_drive = 1'b0;
      o_data = 16'h0000;
   end
   // Garbage first, so a too-early capture shows up
   always @(negedge i_rd_n) begin
      o_drive = sel;
      o_data = ~o_data;
      #(i_slow ? 60 : 10);
      o_data = mem[int'(key)];
   end
   always @(posedge i_rd_n) o_drive = 1'b0;
   always @(posedge i_wr_n) begin
      if (sel) mem[int'(key)] = i_data;
   end
endmodule

// ---- tb/ext_mem_data_strobes_bench.sv ----
/* Self-checking bench for the external memory pin logic.
   Assumes default timing parameters and a pulled-up data bus. */
`timescale 1ns/1ps
module ext_mem_data_strobes_bench;
   logic        i_clock = 0, i_rstn = 0, i_req_valid = 0, i_req_write = 0;
   logic        i_req_program = 0, keep = 0, dis = 0, slow = 0;
   logic [16:0] i_req_addr = 0;
   logic [15:0] i_req_wdata = 0;
   logic [8:0]  gsel = 0, gdir = 0, gout = 0, pue = 9'h1ff, ext_in = 9'h1ff;
   wire         req_rdy, rd_vld, busy, rd_n, wr_n, ps_n, ds_n, c_oe_n, spu, m_drv;
   wire  [15:0] rd_data, dout, oe_n, m_data;
   wire  [16:0] addr;
   wire  [8:0]  pf_in, pf_pu;
   wire  [15:0] pin = (~oe_n & dout) | (oe_n & (m_drv ? m_data : {ext_in, 7'h7f}));
   int          n_errors = 0, n_tests = 0, seed = 95721;
   logic [15:0] ref_mem [int];
   logic [15:0] exq [$];
   logic [16:0] adr [10];
   emd_ext_mem_port u_emd_ext_mem_port (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_program(i_req_program),
      .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .o_req_ready(req_rdy),
      .o_rd_valid(rd_vld), .o_rd_data(rd_data), .o_busy(busy), .i_bus_keep_driven(keep),
      .i_port_f_gpio_sel(gsel), .i_port_f_dir_out(gdir), .i_port_f_out(gout),
      .i_port_f_pullup_enable(pue), .i_ctrl_pullup_disable(dis), .o_port_f_in(pf_in),
      .i_ext_data_bus(pin), .o_ext_data_bus(dout), .o_ext_data_oe_n(oe_n),
      .o_port_f_pullup_on(pf_pu), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ext_address_bus(addr),
      .o_program_mem_select_n(ps_n), .o_data_mem_select_n(ds_n), .o_ctrl_oe_n(c_oe_n),
      .o_strobe_pullup_on(spu));
   emd_sram_model u_emd_sram_model (.i_slow(slow), .i_rd_n(rd_n), .i_wr_n(wr_n),
      .i_prog_sel_n(ps_n), .i_data_sel_n(ds_n), .i_addr(addr), .i_data(pin),
      .o_drive(m_drv), .o_data(m_data));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize;
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // Holds the request until the FIFO takes it; a full FIFO stalls here, failing the run after 300 cycles
   task automatic push(input logic w, input logic p, input logic [16:0] a,
                       input logic [15:0] d);
      int t;
      t = 0;
      i_req_valid <= 1;
      i_req_write <= w;
      i_req_program <= p;
      i_req_addr <= a;
      i_req_wdata <= d;
      do begin
         @(posedge i_clock);
         t++;
      end while (req_rdy !== 1'b1 && t < 300);
      if (t >= 300) begin
         n_errors++;
         summarize;
      end
      if (w) ref_mem[int'({p, a})] = d;
      else exq.push_back(ref_mem[int'({p, a})]);
   endtask
   task automatic settle;
      int t, q;
      t = 0;
      q = 0;
      while (q < 4 && t < 2000) begin
         @(posedge i_clock);
         t++;
         q = (busy === 1'b0 && exq.size() == 0) ? q + 1 : 0;
      end
      if (t >= 2000) begin
         n_errors++;
         summarize;
      end
   endtask
   initial forever #50 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      if (rd_vld === 1'b1) begin
         if (exq.size() == 0) check("rd_extra", 1, 0);
         else check("rd_data", rd_data, exq.pop_front());
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      cyc(11);
      check("rst_oe", oe_n, 16'hffff);
      check("rst_pins", {rd_n, wr_n, c_oe_n, spu, req_rdy}, 5'b11110);
      check("rst_pu", pf_pu, 9'h1ff);
      @(posedge i_clock);
      i_rstn <= 1;
      cyc(3);
      for (int r = 0; r < 2; r++) begin
         slow <= r[0];
         keep <= r[0];
         for (int i = 0; i < 10; i++) begin
            adr[i] = 17'($random(seed));
            push(1, i[0], adr[i], 16'($random(seed)));
         end
         for (int i = 0; i < 10; i++) push(0, i[0], adr[9 - i], 16'h0000);
         i_req_valid <= 0;
         settle;
         check("idle_ctrl_oe", c_oe_n, !keep);
         check("idle_data_oe", oe_n, {16{!keep}});
      end
      foreach (ref_mem[k]) check("mem", u_emd_sram_model.mem[k], ref_mem[k]);
      for (int k = 0; k < 4; k++) begin
         pue <= 9'($random(seed));
         dis <= k[0];
         gsel <= 9'($random(seed));
         gdir <= 9'($random(seed));
         gout <= 9'($random(seed));
         ext_in <= 9'($random(seed));
         cyc(6);
         check("pf_pu", pf_pu, pue);
         check("st_pu", spu, !dis);
         check("pf_oe", oe_n[15:7], gsel & ~gdir);
         check("pf_out", dout[15:7] & gsel & gdir, gout & gsel & gdir);
         check("pf_in", pf_in & gsel & ~gdir, ext_in & gsel & ~gdir);
      end
      summarize;
   end
endmodule
